// ==== hdl/bnvm_pkg.sv ====
// Purpose: Shared constants and types of the byte-wide non-volatile memory access controller.
// Assumes: 6-bit I/O register addresses, 8-bit registers, synchronous core bus.
// Notes: Offsets are I/O-space addresses; the high index register sits at a chosen free address.

package bnvm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_CONTROL = 6'h1c;
  localparam logic [5:0] ADDR_BYTE_VALUE = 6'h1d;
  localparam logic [5:0] ADDR_INDEX_LOW = 6'h1e;
  localparam logic [5:0] ADDR_INDEX_HIGH = 6'h1f;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_PROGRAM_STROBE = 1;
  localparam int BIT_PROGRAM_ARM = 2;
  localparam int BIT_READY_IRQ_ENABLE = 3;
  localparam int BIT_PROG_MODE_LO = 4;
  localparam int BIT_PROG_MODE_HI = 5;

  // ---------------------------------------------------------------
  // Reset values and cycle counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE_VALUE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;

  // ---------------------------------------------------------------
  // Programming times, counted in calibrated oscillator ticks
  // ---------------------------------------------------------------
  localparam int PROG_TIME_ATOMIC_US = 3400;
  localparam int PROG_TIME_SPLIT_US = 1800;
  localparam int OSC_TICK_NS = 1000;
  localparam int PROG_TICKS_ATOMIC = (PROG_TIME_ATOMIC_US * 1000) / OSC_TICK_NS;
  localparam int PROG_TICKS_SPLIT = (PROG_TIME_SPLIT_US * 1000) / OSC_TICK_NS;
  localparam int TIMER_WIDTH = 16;

  // ---------------------------------------------------------------
  // Programming modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BNVM_MODE_ATOMIC = 2'h0,
    BNVM_MODE_ERASE = 2'h1,
    BNVM_MODE_WRITE = 2'h2,
    BNVM_MODE_RESERVED = 2'h3
  } bnvm_mode_type;

endpackage : bnvm_pkg

// ==== hdl/bnvm_prog_timer.sv ====
// Purpose: Counts oscillator ticks for one programming operation.
// Assumes: Tick input is one clock wide and synchronous to the clock.
// Notes: A running count ignores reset so an operation always completes.

`timescale 1ns/1ps
`default_nettype none

module bnvm_prog_timer #(
  parameter int WIDTH = bnvm_pkg::TIMER_WIDTH
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic start_i, // Load and start
  input wire logic [WIDTH-1:0] ticks_i, // Ticks to run
  input wire logic osc_tick_i, // Calibrated oscillator tick
  output logic done_o, // Pulse in the expiry cycle
  output logic running_o // Count in progress
);

  typedef struct packed {
    logic running;
    logic [WIDTH-1:0] remain;
  } bnvm_timer_state_type;

  bnvm_timer_state_type st_ff;
  bnvm_timer_state_type nxt_st;

  // Expiry on the last tick
  assign done_o = st_ff.running && osc_tick_i && (st_ff.remain <= WIDTH'(1));
  assign running_o = st_ff.running;

  // Next count
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.running) begin
      if (done_o) begin
        nxt_st.running = 1'b0;
        nxt_st.remain = '0;
      end else if (osc_tick_i) begin
        nxt_st.remain = st_ff.remain - WIDTH'(1);
      end
    end else if (!rst_n_i) begin
      nxt_st = '0;
    end else if (start_i) begin
      nxt_st.running = 1'b1;
      nxt_st.remain = ticks_i;
    end
  end

  // State register, reset handled above so a running count survives
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

endmodule : bnvm_prog_timer

`default_nettype wire

// ==== hdl/bnvm_byte_array.sv ====
// Purpose: Storage cells of the non-volatile data memory.
// Assumes: One erase, write or combined erase and write per call, read is combinational.
// Notes: Writing only clears bits, so an unerased byte is corrupted.

`timescale 1ns/1ps
`default_nettype none

module bnvm_byte_array #(
  parameter int DEPTH = 512,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i, // Core clock
  input wire logic erase_i, // Set byte to erased value
  input wire logic write_i, // Program byte
  input wire logic [AW-1:0] index_i, // Byte index
  input wire logic [7:0] wdata_i, // Byte to program
  output logic [7:0] rdata_o // Byte at index
);

  logic [7:0] cells [DEPTH];

  // Combined erase and write per the request flags
  always_ff @(posedge clk_i) begin
    if (erase_i && write_i) begin
      cells[index_i] <= wdata_i;
    end else if (erase_i) begin
      cells[index_i] <= bnvm_pkg::ERASED_BYTE;
    end else if (write_i) begin
      cells[index_i] <= cells[index_i] & wdata_i;
    end
  end

  assign rdata_o = cells[index_i];

endmodule : bnvm_byte_array

`default_nettype wire

// ==== hdl/bnvm_ctrl.sv ====
// Purpose: Byte non-volatile memory access controller on the core I/O register bus.
// Assumes: I/O bus signals synchronous to SYS_CLK_I; oscillator tick is a one-cycle pulse.
// Notes: Register read data is returned one clock after the read request.

`timescale 1ns/1ps
`default_nettype none

module bnvm_ctrl #(
  parameter int CAPACITY = 512,
  parameter int TICKS_ATOMIC = bnvm_pkg::PROG_TICKS_ATOMIC,
  parameter int TICKS_SPLIT = bnvm_pkg::PROG_TICKS_SPLIT
) (
  input wire logic SYS_CLK_I, // Core and I/O clock
  input wire logic RESETN_I, // Synchronous reset, active low
  input wire logic [5:0] IO_ADDR_I, // I/O register address
  input wire logic IO_WE_I, // Register write request
  input wire logic [7:0] IO_WDATA_I, // Register write data
  input wire logic IO_RE_I, // Register read request
  input wire logic GLOBAL_IRQ_EN_I, // Core status word global interrupt enable
  input wire logic OSC_TICK_I, // Calibrated oscillator tick
  output logic [7:0] IO_RDATA_O, // Register read data
  output logic READY_IRQ_O, // Ready interrupt request, level
  output logic CORE_STALL_O, // Halts the core
  output logic BUSY_O // Programming in progress
);

  localparam int AW = $clog2(CAPACITY);
  localparam int TW = bnvm_pkg::TIMER_WIDTH;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bnvm_pkg::bnvm_mode_type prog_mode_field;
    logic ready_irq_enable;
    logic [2:0] arm_cnt;
    logic program_strobe;
    bnvm_pkg::bnvm_mode_type op_mode;
    logic [7:0] op_byte;
    logic [AW-1:0] nv_byte_index;
    logic [7:0] nv_byte_value;
    logic [2:0] stall_cnt;
    logic stall;
    logic irq;
    logic [7:0] rdata;
  } bnvm_state_type;

  bnvm_state_type st_ff;
  bnvm_state_type nxt_st;

  logic wr_control;
  logic wr_value;
  logic wr_low;
  logic wr_high;
  logic prog_req;
  logic prog_start;
  logic read_req;
  logic read_ok;
  logic timer_done;
  logic timer_running;
  logic [TW-1:0] start_ticks;
  logic [7:0] array_rdata;
  logic [7:0] index_low_view;
  logic [7:0] index_high_view;
  logic [7:0] control_view;
  logic do_erase;
  logic do_write;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Register write strobes
  assign wr_control = IO_WE_I && (IO_ADDR_I == bnvm_pkg::ADDR_CONTROL);
  assign wr_value = IO_WE_I && (IO_ADDR_I == bnvm_pkg::ADDR_BYTE_VALUE);
  assign wr_low = IO_WE_I && (IO_ADDR_I == bnvm_pkg::ADDR_INDEX_LOW);
  assign wr_high = IO_WE_I && (IO_ADDR_I == bnvm_pkg::ADDR_INDEX_HIGH);

  // Program strobe accepted only inside the arm window, when idle, with a legal mode
  assign prog_req = wr_control && IO_WDATA_I[bnvm_pkg::BIT_PROGRAM_STROBE];
  assign prog_start = prog_req && (st_ff.arm_cnt != 3'h0)
                      && !st_ff.program_strobe
                      && (st_ff.prog_mode_field != bnvm_pkg::BNVM_MODE_RESERVED)
                      && RESETN_I;

  // Read strobe rejected while programming
  assign read_req = wr_control && IO_WDATA_I[bnvm_pkg::BIT_READ_STROBE];
  assign read_ok = read_req && !st_ff.program_strobe && RESETN_I;

  // Duration of the selected mode
  always_comb begin
    start_ticks = TW'(TICKS_SPLIT);
    if (st_ff.prog_mode_field == bnvm_pkg::BNVM_MODE_ATOMIC) begin
      start_ticks = TW'(TICKS_ATOMIC);
    end
  end

  // ---------------------------------------------------------------
  // Programming timer and storage
  // ---------------------------------------------------------------
  bnvm_prog_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESETN_I),
    .start_i(prog_start),
    .ticks_i(start_ticks),
    .osc_tick_i(OSC_TICK_I),
    .done_o(timer_done),
    .running_o(timer_running)
  );

  // Commit the operation to the cells when the timer expires
  assign do_erase = timer_done && (st_ff.op_mode != bnvm_pkg::BNVM_MODE_WRITE);
  assign do_write = timer_done && (st_ff.op_mode != bnvm_pkg::BNVM_MODE_ERASE);

  bnvm_byte_array #(
    .DEPTH(CAPACITY),
    .AW(AW)
  ) u_array (
    .clk_i(SYS_CLK_I),
    .erase_i(do_erase),
    .write_i(do_write),
    .index_i(st_ff.nv_byte_index),
    .wdata_i(st_ff.op_byte),
    .rdata_o(array_rdata)
  );

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  // Index split with unimplemented bits reading zero
  always_comb begin
    logic [15:0] wide_index;
    wide_index = '0;
    wide_index[AW-1:0] = st_ff.nv_byte_index;
    index_low_view = wide_index[7:0];
    index_high_view = {7'h00, wide_index[8]};
  end

  // Control view with reserved top bits and read strobe as zero
  always_comb begin
    control_view = 8'h00;
    control_view[bnvm_pkg::BIT_PROG_MODE_HI] = st_ff.prog_mode_field[1];
    control_view[bnvm_pkg::BIT_PROG_MODE_LO] = st_ff.prog_mode_field[0];
    control_view[bnvm_pkg::BIT_READY_IRQ_ENABLE] = st_ff.ready_irq_enable;
    control_view[bnvm_pkg::BIT_PROGRAM_ARM] = (st_ff.arm_cnt != 3'h0);
    control_view[bnvm_pkg::BIT_PROGRAM_STROBE] = st_ff.program_strobe;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] new_index;
    new_index = '0;
    new_index[AW-1:0] = st_ff.nv_byte_index;
    nxt_st = st_ff;

    // Arm window runs down and clears itself
    if (st_ff.arm_cnt != 3'h0) begin
      nxt_st.arm_cnt = st_ff.arm_cnt - 3'h1;
    end

    // Control writes; mode field frozen while busy
    if (wr_control) begin
      nxt_st.ready_irq_enable = IO_WDATA_I[bnvm_pkg::BIT_READY_IRQ_ENABLE];
      if (!st_ff.program_strobe) begin
        nxt_st.prog_mode_field = bnvm_pkg::bnvm_mode_type'(
          IO_WDATA_I[bnvm_pkg::BIT_PROG_MODE_HI:bnvm_pkg::BIT_PROG_MODE_LO]);
      end
      if (IO_WDATA_I[bnvm_pkg::BIT_PROGRAM_ARM]) begin
        nxt_st.arm_cnt = bnvm_pkg::ARM_WINDOW_CYCLES;
      end
    end

    // Data register written by software
    if (wr_value) begin
      nxt_st.nv_byte_value = IO_WDATA_I;
    end

    // Index writes blocked while programming
    if (!st_ff.program_strobe) begin
      if (wr_low) begin
        new_index[7:0] = IO_WDATA_I;
      end
      if (wr_high) begin
        new_index[8] = IO_WDATA_I[0];
      end
    end
    nxt_st.nv_byte_index = new_index[AW-1:0];

    // Stall countdown
    if (st_ff.stall_cnt != 3'h0) begin
      nxt_st.stall_cnt = st_ff.stall_cnt - 3'h1;
    end

    // Start programming with the byte and mode latched
    if (prog_start) begin
      nxt_st.program_strobe = 1'b1;
      nxt_st.op_mode = st_ff.prog_mode_field;
      nxt_st.op_byte = st_ff.nv_byte_value;
      nxt_st.stall_cnt = bnvm_pkg::PROG_STALL_CYCLES;
    end

    // Read the addressed byte straight into the data register
    if (read_ok) begin
      nxt_st.nv_byte_value = array_rdata;
      nxt_st.stall_cnt = bnvm_pkg::READ_STALL_CYCLES;
    end

    // Busy ends in the expiry cycle
    if (timer_done) begin
      nxt_st.program_strobe = 1'b0;
    end

    // Reset keeps an operation in progress and its mode
    if (!RESETN_I) begin
      nxt_st.ready_irq_enable = 1'b0;
      nxt_st.arm_cnt = 3'h0;
      nxt_st.nv_byte_value = bnvm_pkg::RESET_BYTE_VALUE;
      nxt_st.stall_cnt = 3'h0;
      nxt_st.rdata = 8'h00;
      if (!timer_running) begin
        nxt_st.prog_mode_field = bnvm_pkg::BNVM_MODE_ATOMIC;
        nxt_st.program_strobe = 1'b0;
      end
    end

    // Registered outputs
    nxt_st.stall = (nxt_st.stall_cnt != 3'h0);
    nxt_st.irq = nxt_st.ready_irq_enable && GLOBAL_IRQ_EN_I
                 && !nxt_st.program_strobe;

    // Read data mux, unmapped addresses read zero
    if (RESETN_I && IO_RE_I) begin
      unique case (IO_ADDR_I)
        bnvm_pkg::ADDR_CONTROL: nxt_st.rdata = control_view;
        bnvm_pkg::ADDR_BYTE_VALUE: nxt_st.rdata = st_ff.nv_byte_value;
        bnvm_pkg::ADDR_INDEX_LOW: nxt_st.rdata = index_low_view;
        bnvm_pkg::ADDR_INDEX_HIGH: nxt_st.rdata = index_high_view;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset values are chosen in the next-state logic
  always_ff @(posedge SYS_CLK_I) begin
    st_ff <= nxt_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign IO_RDATA_O = st_ff.rdata;
  assign READY_IRQ_O = st_ff.irq;
  assign CORE_STALL_O = st_ff.stall;
  assign BUSY_O = st_ff.program_strobe;

endmodule : bnvm_ctrl

`default_nettype wire

// ==== sim/bnvm_ctrl_sva.sv ====
// Purpose: Port-level checks of the byte memory access controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Busy length is counted in oscillator ticks.
`timescale 1ns/1ps
`default_nettype none
module bnvm_ctrl_sva #(
  parameter int TICKS_ATOMIC = 3400,
  parameter int TICKS_SPLIT = 1800
) (
  input wire logic SYS_CLK_I, // Clock
  input wire logic RESETN_I, // Reset, active low
  input wire logic [5:0] IO_ADDR_I, // Address
  input wire logic IO_WE_I, // Write request
  input wire logic [7:0] IO_WDATA_I, // Write data
  input wire logic IO_RE_I, // Read request
  input wire logic GLOBAL_IRQ_EN_I, // Global enable
  input wire logic OSC_TICK_I, // Oscillator tick
  input wire logic [7:0] IO_RDATA_O, // Read data
  input wire logic READY_IRQ_O, // Ready request
  input wire logic CORE_STALL_O, // Core halt
  input wire logic BUSY_O // Busy
);
  logic [15:0] tick_cnt_ff;
  logic [15:0] nxt_tick_cnt;
  logic ctl_wr;
  // Ticks seen while busy; kept through reset like the timer
  always_comb begin
    nxt_tick_cnt = BUSY_O ? tick_cnt_ff + 16'(OSC_TICK_I) : 16'h0000;
  end
  always_ff @(posedge SYS_CLK_I) begin
    tick_cnt_ff <= nxt_tick_cnt;
  end
  assign ctl_wr = IO_WE_I && (IO_ADDR_I == bnvm_pkg::ADDR_CONTROL);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  property p_busy_len;
    $fell(BUSY_O) && $past(RESETN_I) |-> (tick_cnt_ff == 16'(TICKS_ATOMIC) || tick_cnt_ff == 16'(TICKS_SPLIT));
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length off");
  property p_prog_stall;
    $rose(BUSY_O) |-> CORE_STALL_O [*2] ##1 !CORE_STALL_O;
  endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("program halt length");
  property p_read_stall;
    ctl_wr && IO_WDATA_I[1:0] == 2'b01 && !BUSY_O && !CORE_STALL_O |=> CORE_STALL_O [*4] ##1 !CORE_STALL_O;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read halt length");
  property p_busy_refuse;
    ctl_wr && IO_WDATA_I[1:0] != 2'b00 && BUSY_O ##1 BUSY_O |-> !CORE_STALL_O;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("strobe taken while busy");
  property p_irq_idle;
    READY_IRQ_O |-> !BUSY_O;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("ready while busy");
  property p_irq_gie;
    !GLOBAL_IRQ_EN_I |=> !READY_IRQ_O;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("ready without global enable");
  property p_ctrl_zero;
    IO_RE_I && IO_ADDR_I == bnvm_pkg::ADDR_CONTROL |=> IO_RDATA_O[7:6] == 2'b00 && !IO_RDATA_O[0];
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control reserved bits");
  property p_high_zero;
    IO_RE_I && IO_ADDR_I == bnvm_pkg::ADDR_INDEX_HIGH |=> IO_RDATA_O[7:1] == 7'h00;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high index reserved bits");
  property p_busy_bit;
    IO_RE_I && IO_ADDR_I == bnvm_pkg::ADDR_CONTROL |=> IO_RDATA_O[1] == $past(BUSY_O);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("strobe bit differs from busy");
  property p_rdata_hold;
    !IO_RE_I |=> $stable(IO_RDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  c_prog: cover property ($fell(BUSY_O));
  c_read: cover property ($rose(CORE_STALL_O) && !BUSY_O);
  c_irq: cover property ($rose(READY_IRQ_O));
endmodule : bnvm_ctrl_sva
bind bnvm_ctrl bnvm_ctrl_sva #(.TICKS_ATOMIC(TICKS_ATOMIC), .TICKS_SPLIT(TICKS_SPLIT)) u_sva (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .IO_ADDR_I(IO_ADDR_I), .IO_WE_I(IO_WE_I),
  .IO_WDATA_I(IO_WDATA_I), .IO_RE_I(IO_RE_I), .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I),
  .OSC_TICK_I(OSC_TICK_I), .IO_RDATA_O(IO_RDATA_O), .READY_IRQ_O(READY_IRQ_O),
  .CORE_STALL_O(CORE_STALL_O), .BUSY_O(BUSY_O));
`default_nettype wire

// ==== sim/bnvm_core_model.sv ====
// Purpose: Core model issuing register reads and writes.
// Assumes: A halted core issues nothing.
// Notes: Released lines carry inverted values.
`timescale 1ns/1ps
`default_nettype none
module bnvm_core_model (
  input wire logic clk_i, // Clock
  input wire logic stall_i, // Core halt
  input wire logic [7:0] rdata_i, // Read data
  output logic [5:0] addr_o, // Address
  output logic we_o, // Write request
  output logic [7:0] wdata_o, // Write data
  output logic re_o // Read request
);
  int hang = 0;
  int gap = 0;
  // Idle bus at time zero
  initial begin
    addr_o = 6'h00;
    we_o = 1'b0;
    wdata_o = 8'h00;
    re_o = 1'b0;
  end
  // Optional slowness, then wait out a halt
  task automatic hold_off();
    int n;
    n = 0;
    repeat (gap) @(posedge clk_i);
    #1;
    while (stall_i !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (stall_i !== 1'b0) begin
      hang++;
    end
  endtask : hold_off
  // One register write
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    hold_off();
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    we_o <= 1'b1;
    @(posedge clk_i);
    we_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~v;
  endtask : wr
  // One register read
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    hold_off();
    @(posedge clk_i);
    addr_o <= a;
    re_o <= 1'b1;
    @(posedge clk_i);
    re_o <= 1'b0;
    addr_o <= ~a;
    #1;
    v = rdata_i;
  endtask : rd
endmodule : bnvm_core_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the byte memory access controller.
// Assumes: Small tick counts keep programming short.
// Notes: A byte is erased before any write-only check.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [5:0] A_CTL = bnvm_pkg::ADDR_CONTROL;
  localparam logic [5:0] A_VAL = bnvm_pkg::ADDR_BYTE_VALUE;
  localparam logic [5:0] A_LO = bnvm_pkg::ADDR_INDEX_LOW;
  localparam logic [5:0] A_HI = bnvm_pkg::ADDR_INDEX_HIGH;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic gie = 1'b0;
  logic tick_raw = 1'b0;
  logic [5:0] io_addr;
  logic io_we;
  logic [7:0] io_wdata;
  logic io_re;
  logic [7:0] io_rdata;
  logic ready_irq;
  logic core_stall;
  logic busy;
  wire logic osc_tick;
  logic [7:0] d;
  int miscompares = 0;
  int samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  // Tick every other cycle, held off while a write is taken
  always @(posedge sys_clk) tick_raw <= ~tick_raw;
  assign osc_tick = tick_raw & ~io_we;
  bnvm_ctrl #(.CAPACITY(512), .TICKS_ATOMIC(12), .TICKS_SPLIT(6)) dut (
    .SYS_CLK_I(sys_clk), .RESETN_I(resetn), .IO_ADDR_I(io_addr), .IO_WE_I(io_we),
    .IO_WDATA_I(io_wdata), .IO_RE_I(io_re), .GLOBAL_IRQ_EN_I(gie), .OSC_TICK_I(osc_tick),
    .IO_RDATA_O(io_rdata), .READY_IRQ_O(ready_irq), .CORE_STALL_O(core_stall), .BUSY_O(busy));
  bnvm_core_model core (.clk_i(sys_clk), .stall_i(core_stall), .rdata_i(io_rdata),
    .addr_o(io_addr), .we_o(io_we), .wdata_o(io_wdata), .re_o(io_re));
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  // Bounded wait for busy to drop
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (busy !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_idle
  // Index, data, arm, strobe
  task automatic prog(input logic [7:0] ctl, input logic [8:0] idx, input logic [7:0] val);
    core.wr(A_CTL, ctl);
    core.wr(A_LO, idx[7:0]);
    core.wr(A_HI, {7'h00, idx[8]});
    core.wr(A_VAL, val);
    core.wr(A_CTL, ctl | 8'h04);
    core.wr(A_CTL, ctl | 8'h06);
    #1;
  endtask : prog
  // Stored byte through the read strobe, after polling busy
  task automatic fetch(input logic [8:0] idx, output logic [7:0] v);
    wait_idle();
    core.wr(A_LO, idx[7:0]);
    core.wr(A_HI, {7'h00, idx[8]});
    core.wr(A_CTL, 8'h01);
    core.rd(A_VAL, v);
  endtask : fetch
  // Reset values, reserved bits, unmapped read, slow core
  task automatic t_regs();
    core.gap = 3;
    core.rd(A_CTL, d);
    chk(d, 8'h00);
    core.rd(A_VAL, d);
    chk(d, bnvm_pkg::RESET_BYTE_VALUE);
    core.rd(6'h00, d);
    chk(d, 8'h00);
    core.wr(A_HI, 8'hff);
    core.rd(A_HI, d);
    chk(d, 8'h01);
    core.wr(A_CTL, 8'hc8);
    core.rd(A_CTL, d);
    chk(d, 8'h08);
    core.gap = 0;
  endtask : t_regs
  // Erase, write-only, atomic, reserved on one byte
  task automatic t_modes();
    logic [7:0] ctl [4] = '{8'h10, 8'h20, 8'h00, 8'h30};
    logic [7:0] val [4] = '{8'h00, 8'h3c, 8'ha5, 8'h5a};
    logic [7:0] want [4] = '{bnvm_pkg::ERASED_BYTE, 8'h3c, 8'ha5, 8'ha5};
    for (int i = 0; i < 4; i++) begin
      prog(ctl[i], 9'h105, val[i]);
      chk(8'(busy), 8'(i < 3));
      fetch(9'h105, d);
      chk(d, want[i]);
    end
  endtask : t_modes
  // Mode, index and read strobe refused while busy
  task automatic t_busy();
    prog(8'h00, 9'h105, 8'h11);
    core.wr(A_CTL, 8'h20);
    core.rd(A_CTL, d);
    chk(d & 8'h32, 8'h02);
    core.wr(A_LO, 8'h00);
    core.rd(A_LO, d);
    chk(d, 8'h05);
    core.wr(A_CTL, 8'h01);
    core.rd(A_VAL, d);
    chk(d, 8'h11);
    fetch(9'h105, d);
    chk(d, 8'h11);
  endtask : t_busy
  // Strobe without arm, arm clearing, window edges
  task automatic t_arm();
    core.wr(A_CTL, 8'h12);
    #1;
    chk(8'(busy), 8'h00);
    core.wr(A_CTL, 8'h14);
    core.rd(A_CTL, d);
    chk(d, 8'h14);
    @(posedge sys_clk);
    core.rd(A_CTL, d);
    chk(d, 8'h10);
    for (int k = 2; k < 4; k++) begin
      core.wr(A_CTL, 8'h14);
      repeat (k) @(posedge sys_clk);
      core.wr(A_CTL, 8'h16);
      #1;
      chk(8'(busy), 8'(k == 2));
      wait_idle();
    end
  endtask : t_arm
  // Ready request against enables and busy
  task automatic t_irq();
    core.wr(A_CTL, 8'h08);
    @(posedge sys_clk) gie <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(8'(ready_irq), 8'h01);
    @(posedge sys_clk) gie <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(8'(ready_irq), 8'h00);
    @(posedge sys_clk) gie <= 1'b1;
    prog(8'h08, 9'h0a7, 8'h77);
    chk(8'(ready_irq), 8'h00);
    wait_idle();
    chk(8'(ready_irq), 8'h01);
    core.wr(A_CTL, 8'h00);
    @(posedge sys_clk);
    #1;
    chk(8'(ready_irq), 8'h00);
  endtask : t_irq
  task automatic pulse_reset();
    @(posedge sys_clk) resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : pulse_reset
  // Reset during an erase, then reset while idle
  task automatic t_rst();
    prog(8'h10, 9'h0a7, 8'h00);
    pulse_reset();
    #1;
    chk(8'(busy), 8'h01);
    wait_idle();
    core.rd(A_CTL, d);
    chk(d, 8'h10);
    core.rd(A_VAL, d);
    chk(d, 8'h00);
    fetch(9'h0a7, d);
    chk(d, 8'hff);
    core.wr(A_CTL, 8'h20);
    pulse_reset();
    core.rd(A_CTL, d);
    chk(d, 8'h00);
  endtask : t_rst
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_modes();
    t_busy();
    t_arm();
    t_irq();
    t_rst();
    chk(8'(core.hang), 8'h00);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
